// [hdl/mic_consts.vh]
// constants for the interrupt controller
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH
`define MIC_ADDR_SENSE 8'h00
`define MIC_ADDR_PINSEL 8'h04
`define MIC_ADDR_STATUS 8'h08
`define MIC_ADDR_ENABLE 8'h0C
`define MIC_ADDR_PENDING 8'h10
`define MIC_ADDR_VECTOR 8'h14
`define MIC_RST_SENSE 8'h00
`define MIC_RST_PINSEL 8'h00
`define MIC_VEC_RESET 16'hFFFE
`define MIC_VEC_TRAP 16'hFFFC
`define MIC_VEC_SRC0 16'hFFFA
`define MIC_NUM_SRC 14
`define MIC_SENSE_FALL_LOW 2'b00
`define MIC_SENSE_RISE 2'b01
`define MIC_SENSE_FALL 2'b10
`define MIC_SENSE_BOTH 2'b11
`define MIC_WAKE_HALT 14'h1_01E
`define MIC_WAKE_ACTIVE 14'h0_A00
`define MIC_WAKE_AWU 14'h0_001
`endif

// [hdl/mic_ext_line.v]
// one external interrupt line: pin select and sensitivity detector
`timescale 1ns/1ps
`include "mic_consts.vh"
module mic_ext_line
(
    input wire hclk,
    input wire hresetn,
    input wire [3:0] pins,
    input wire [1:0] pin_sel,
    input wire [1:0] sense,
    input wire ack,
    output reg req
);
    reg prev;
    wire connected;
    wire level;
    wire rise;
    wire fall;
    reg hit;
    reg level_mode;
    // code 00 disconnects the line; pins[0] is tied high by the parent
    assign connected = pin_sel != 2'b00;
    // line idles high when no pin is routed
    assign level = pins[pin_sel];
    assign rise = level & ~prev;
    assign fall = ~level & prev;
    // RL10 decode sense
    always @*
    begin
        hit = 1'b0;
        level_mode = 1'b0;
        case (sense)
            `MIC_SENSE_FALL_LOW:
            begin
                hit = ~level;
                level_mode = 1'b1;
            end
            `MIC_SENSE_RISE: hit = rise;
            `MIC_SENSE_FALL: hit = fall;
            default: hit = rise | fall;
        endcase
    end
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev <= 1'b1;
            req <= 1'b0;
        end
        else
        begin
            prev <= level;
            // RL16 low level masks
            // a falling-edge request must survive the low level that follows it
            if (!connected || (level_mode && level) || (sense == `MIC_SENSE_RISE && !level))
                req <= 1'b0;
            // RL14 edge latched, cleared on entry
            else if (hit)
                req <= 1'b1;
            else if (ack)
                req <= 1'b0;
        end
    end
endmodule // mic_ext_line

// [hdl/mic_prio.v]
// fixed priority encoder with vector generation
`timescale 1ns/1ps
`include "mic_consts.vh"
module mic_prio
(
    input wire [13:0] active,
    input wire trap,
    input wire reset_req,
    output reg valid,
    output reg [15:0] vector,
    output reg [3:0] index
);
    integer i;
    // RL6 fixed priority order
    always @*
    begin
        valid = 1'b0;
        vector = `MIC_VEC_SRC0;
        index = 4'h0;
        for (i = `MIC_NUM_SRC - 1; i >= 0; i = i - 1)
        begin
            if (active[i])
            begin
                valid = 1'b1;
                index = i[3:0];
                // RL5 two-byte vectors
                vector = `MIC_VEC_SRC0 - {11'h000, i[3:0], 1'b0};
            end
        end
        if (trap)
        begin
            valid = 1'b1;
            vector = `MIC_VEC_TRAP;
        end
        if (reset_req)
        begin
            valid = 1'b1;
            vector = `MIC_VEC_RESET;
        end
    end
endmodule // mic_prio

// [hdl/mic_top.v]
// interrupt controller top with ahb-lite register slave
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "mic_consts.vh"
// Contract
// RL1 - request needs flag, enable, mask clear
// RL2 - disabled or masked request stays pending
// RL3 - clear by zero write or sequence
// RL4 - clearing sequence drops pending latch
// RL5 - fixed two-byte vector per source
// RL6 - reset, trap, then sources 0..13
// RL7 - wake sources for halt and auto-wakeup
// RL8 - sources 9, 11 wake active halt
// RL9 - sensitivity register four 2-bit fields
// RL10 - sensitivity code decode
// RL11 - sensitivity writes only while masked
// RL12 - pin routing lines 3 and 2
// RL13 - pin routing lines 1 and 0
// RL14 - edge request cleared on service entry
// RL15 - service only unmasked; mask set after reset
// RL16 - low level masks nanded line
// RL17 - single request plus vector each cycle
module mic_top
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire [7:0] port_a,
    input wire [7:0] port_b,
    input wire [13:0] periph_flag_set,
    input wire [13:0] assoc_access,
    input wire global_mask,
    input wire trap_req,
    input wire reset_req,
    input wire service_ack,
    input wire [3:0] service_index,
    input wire in_halt,
    input wire in_active_halt,
    input wire in_awu_halt,
    output wire core_irq,
    output reg [15:0] core_vector,
    output reg wakeup
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] ext_irq_sensitivity;
    reg [7:0] ext_irq_pin_select;
    reg [13:0] status;
    reg [13:0] enable;
    reg [13:0] pending;
    reg [13:0] armed;
    reg wr_pend;
    reg [7:0] wr_addr;
    wire [3:0] ext_req;
    wire [13:0] flags;
    wire [13:0] active;
    wire [13:0] ack_vec;
    wire [13:0] zero_clr;
    wire [13:0] seq_clr;
    wire [13:0] wake_mask;
    wire take;
    wire rd_take;
    wire pr_valid;
    wire [15:0] pr_vector;
    wire [3:0] pr_index;
    wire [3:0] pins0;
    wire [3:0] pins1;
    wire [3:0] pins2;
    wire [3:0] pins3;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel & hready & htrans[1];
    assign rd_take = take & ~hwrite;
    // RL15 masked at start-up, service only unmasked except trap and reset requests, which pass global_mask
    assign core_irq = pr_valid & (~global_mask | trap_req | reset_req) & hresetn;

    // ----------------------------------------
    // external lines
    // ----------------------------------------
    // bit n of each vector is the pin for code n; code 00 reads idle high
    // RL13 line 0 from pa1..3, code 00 disconnected
    assign pins0 = {port_a[3:1], 1'b1};
    // RL13 line 1 from pa4..6
    assign pins1 = {port_a[6:4], 1'b1};
    // RL12 line 2 from pb3, pb5, pb6
    assign pins2 = {port_b[6], port_b[5], port_b[3], 1'b1};
    // RL12 line 3 from pb0..2
    assign pins3 = {port_b[2:0], 1'b1};
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_line
            wire [3:0] pv;
            assign pv = g == 0 ? pins0 : g == 1 ? pins1 : g == 2 ? pins2 : pins3;
            mic_ext_line u_line
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .pins(pv),
                // RL9 field per line
                .pin_sel(ext_irq_pin_select[2*g+1:2*g]),
                .sense(ext_irq_sensitivity[2*g+1:2*g]),
                .ack(ack_vec[g+1]),
                .req(ext_req[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // peripheral flags
    // ----------------------------------------
    assign ack_vec = service_ack ? (14'h0001 << service_index) : 14'h0000;
    assign flags = {status[13:5], ext_req, status[0]};
    // RL3 write zero to status bit
    assign zero_clr = (wr_pend && wr_addr == `MIC_ADDR_STATUS) ? ~hwdata[13:0] : 14'h0000;
    // RL3 status access then associated access
    assign seq_clr = armed & assoc_access;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status <= 14'h0000;
            armed <= 14'h0000;
            pending <= 14'h0000;
        end
        else
        begin
            // set wins over clear
            // bits 1..4 belong to the external lines, not to peripherals
            status <= (status & ~zero_clr & ~seq_clr) | (periph_flag_set & 14'h3FE1);
            if (take && haddr[7:0] == `MIC_ADDR_STATUS)
                armed <= status;
            else
                armed <= armed & ~assoc_access;
            // RL2 latch while disabled or masked
            // RL4 clearing drops the latch
            pending <= ((pending | flags) & ~zero_clr & ~seq_clr & ~ack_vec)
                | (periph_flag_set & 14'h3FE1);
        end
    end
    // RL1 flag and enable gate
    assign active = pending & flags & enable;

    mic_prio u_prio
    (
        .active(active),
        .trap(trap_req),
        .reset_req(reset_req),
        .valid(pr_valid),
        .vector(pr_vector),
        .index(pr_index)
    );

    // ----------------------------------------
    // wakeup and core outputs
    // ----------------------------------------
    // RL7 halt and awu wake sets
    // RL8 active halt wake set
    assign wake_mask = (in_halt ? `MIC_WAKE_HALT : 14'h0000)
        | (in_active_halt ? `MIC_WAKE_ACTIVE : 14'h0000)
        | (in_awu_halt ? (`MIC_WAKE_HALT | `MIC_WAKE_AWU) : 14'h0000);
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            core_vector <= `MIC_VEC_RESET;
            wakeup <= 1'b0;
        end
        else
        begin
            // RL17 vector tracks every cycle
            core_vector <= pr_vector;
            wakeup <= |(pending & flags & enable & wake_mask);
        end
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            ext_irq_sensitivity <= `MIC_RST_SENSE;
            ext_irq_pin_select <= `MIC_RST_PINSEL;
            enable <= 14'h0000;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= take & hwrite;
            wr_addr <= haddr[7:0];
            if (wr_pend)
            begin
                // RL11 sensitivity locked while unmasked
                if (wr_addr == `MIC_ADDR_SENSE && global_mask)
                    ext_irq_sensitivity <= hwdata[7:0];
                else if (wr_addr == `MIC_ADDR_PINSEL)
                    ext_irq_pin_select <= hwdata[7:0];
                else if (wr_addr == `MIC_ADDR_ENABLE)
                    enable <= hwdata[13:0];
            end
            if (rd_take)
            begin
                if (haddr[7:0] == `MIC_ADDR_SENSE)
                    hrdata <= {24'h00_0000, ext_irq_sensitivity};
                else if (haddr[7:0] == `MIC_ADDR_PINSEL)
                    hrdata <= {24'h00_0000, ext_irq_pin_select};
                else if (haddr[7:0] == `MIC_ADDR_STATUS)
                    hrdata <= {18'h0_0000, flags};
                else if (haddr[7:0] == `MIC_ADDR_ENABLE)
                    hrdata <= {18'h0_0000, enable};
                else if (haddr[7:0] == `MIC_ADDR_PENDING)
                    hrdata <= {18'h0_0000, pending};
                else if (haddr[7:0] == `MIC_ADDR_VECTOR)
                    hrdata <= {11'h000, pr_valid, pr_index, pr_vector};
                else
                    hrdata <= 32'h0000_0000;
            end
        end
    end
endmodule // mic_top

// [sim/mic_sva.sv]
// port assertions for the interrupt controller
`timescale 1ns/1ps
`include "mic_consts.vh"
module mic_sva
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire global_mask,
    input wire trap_req,
    input wire reset_req,
    input wire core_irq,
    input wire [15:0] core_vector
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ready_always_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    rdata_stands_a: assert property ($changed(hrdata) |->
        $past(hsel && hready && htrans[1] && !hwrite)) else $error("hrdata moved without read");
    mask_blocks_a: assert property (global_mask && !trap_req && !reset_req |-> !core_irq)
        else $error("request while masked");
    trap_irq_a: assert property (trap_req ##1 trap_req |-> core_irq)
        else $error("trap not requested");
    trap_vec_a: assert property (trap_req && !reset_req |=> core_vector == `MIC_VEC_TRAP)
        else $error("trap vector wrong");
    reset_vec_a: assert property (reset_req |=> core_vector == `MIC_VEC_RESET)
        else $error("reset vector wrong");
    vec_range_a: assert property (!core_vector[0] && core_vector >= 16'hFFE0)
        else $error("vector outside table");
endmodule // mic_sva
bind mic_top mic_sva i_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .global_mask, .trap_req, .reset_req, .core_irq, .core_vector);

// [sim/mic_core_model.sv]
// core model that enters service routines
`timescale 1ns/1ps
module mic_core_model
(
    input wire hclk,
    input wire hresetn,
    input wire core_irq,
    input wire [15:0] core_vector,
    input wire ack_en,
    input wire [1:0] lat,
    output reg service_ack,
    output reg [3:0] service_index
);
    reg [2:0] cnt;
    wire [15:0] offs = 16'hFFFA - core_vector;
    wire want = ack_en && core_irq && core_vector <= 16'hFFFA;
    // margin of three cycles covers the one-cycle vector lag
    wire go = want && cnt == {1'b0, lat} + 3'h3;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 3'h0;
            service_ack <= 1'b0;
            service_index <= 4'h0;
        end
        else
        begin
            cnt <= (go || !want) ? 3'h0 : cnt + 3'h1;
            service_ack <= go;
            service_index <= go ? offs[4:1] : ~service_index;
        end
    end
endmodule // mic_core_model

// [sim/testbench.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "mic_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0000_0000;
    reg [1:0] htrans = 2'b00;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0000_0000;
    reg [7:0] port_a = 8'hFF;
    reg [7:0] port_b = 8'hFF;
    reg [13:0] periph_flag_set = 14'h0000;
    reg [13:0] assoc_access = 14'h0000;
    reg global_mask = 1'b1;
    reg trap_req = 1'b0;
    reg reset_req = 1'b0;
    reg in_halt = 1'b0;
    reg ack_en = 1'b0;
    reg [1:0] lat = 2'h0;
    wire hreadyout, hresp, core_irq, wakeup, service_ack;
    wire [31:0] hrdata;
    wire [15:0] core_vector;
    wire [3:0] service_index;
    integer mismatches = 0;
    integer compares = 0;
    integer i;
    reg [31:0] q;
    mic_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .port_a, .port_b, .periph_flag_set,
        .assoc_access, .global_mask, .trap_req, .reset_req, .service_ack, .service_index,
        .in_halt, .in_active_halt(1'b0), .in_awu_halt(1'b0), .core_irq, .core_vector, .wakeup);
    mic_core_model i_core (.hclk, .hresetn, .core_irq, .core_vector, .ack_en, .lat,
        .service_ack, .service_index);
    initial forever #5 hclk = ~hclk;
    task give_verdict;
    begin
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge hclk);
    endtask
    // a hang on hready counts as a mismatch
    task wait_rdy;
        integer n;
    begin
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n = n + 1;
            if (n > 20)
            begin
                mismatches++;
                give_verdict;
            end
            @(posedge hclk);
        end
    end
    endtask
    task bus(input [7:0] a, input w, input [31:0] d, output [31:0] r);
    begin
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    end
    endtask
    task flush;
    begin
        ack_en <= 1'b1;
        cyc(14);
        ack_en <= 1'b0;
    end
    endtask
    task edge_chk(input v, input e);
    begin
        port_a[1] <= v;
        cyc(4);
        `CHK(core_irq, e)
        flush;
    end
    endtask
    initial
    begin
        cyc(12);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK({core_irq, core_vector}, {1'b0, `MIC_VEC_RESET})
        bus(`MIC_ADDR_PINSEL, 0, 0, q);
        `CHK(q[7:0], `MIC_RST_PINSEL)
        bus(8'h40, 1, 32'h0000_FFFF, q);
        bus(8'h40, 0, 0, q);
        `CHK(q, 32'h0000_0000)
        global_mask <= 1'b0;
        bus(`MIC_ADDR_SENSE, 1, 32'h0000_00E4, q);
        bus(`MIC_ADDR_SENSE, 0, 0, q);
        `CHK(q[7:0], `MIC_RST_SENSE)
        global_mask <= 1'b1;
        bus(`MIC_ADDR_SENSE, 1, 32'h0000_00E4, q);
        bus(`MIC_ADDR_SENSE, 0, 0, q);
        `CHK(q[7:0], 8'hE4)
        bus(`MIC_ADDR_PINSEL, 1, 32'h0000_00E5, q);
        bus(`MIC_ADDR_PINSEL, 0, 0, q);
        `CHK(q[7:0], 8'hE5)
        bus(`MIC_ADDR_ENABLE, 1, 32'h0000_0020, q);
        periph_flag_set <= 14'h2020;
        cyc(1);
        periph_flag_set <= 14'h0000;
        cyc(3);
        `CHK(core_irq, 1'b0)
        bus(`MIC_ADDR_PENDING, 0, 0, q);
        `CHK(q[13:0], 14'h2020)
        global_mask <= 1'b0;
        cyc(3);
        `CHK({core_irq, core_vector}, {1'b1, 16'hFFF0})
        bus(`MIC_ADDR_STATUS, 1, 32'h0000_2000, q);
        cyc(2);
        `CHK(core_irq, 1'b0)
        bus(`MIC_ADDR_STATUS, 0, 0, q);
        assoc_access <= 14'h2000;
        cyc(1);
        assoc_access <= 14'h0000;
        bus(`MIC_ADDR_ENABLE, 1, 32'h0000_203E, q);
        cyc(3);
        `CHK(core_irq, 1'b0)
        in_halt <= 1'b1;
        port_a[4] <= 1'b0;
        cyc(3);
        port_a[4] <= 1'b1;
        cyc(4);
        `CHK({wakeup, core_vector}, {1'b1, 16'hFFF6})
        lat <= 2'h3;
        flush;
        `CHK(core_irq, 1'b0)
        trap_req <= 1'b1;
        cyc(3);
        `CHK({wakeup, core_irq}, 2'b01)
        trap_req <= 1'b0;
        in_halt <= 1'b0;
        reset_req <= 1'b1;
        cyc(2);
        reset_req <= 1'b0;
        port_b[5] <= 1'b0;
        cyc(4);
        `CHK(core_vector, 16'hFFF4)
        port_b[5] <= 1'b1;
        flush;
        for (i = 0; i < 4; i = i + 1)
        begin
            global_mask <= 1'b1;
            bus(`MIC_ADDR_SENSE, 1, i, q);
            global_mask <= 1'b0;
            lat <= i[1:0];
            edge_chk(1'b0, i != 1);
            edge_chk(1'b1, i[0]);
        end
        give_verdict;
    end
endmodule // testbench
